// >>> seq_defs.svh
// Timing, width and field-layout constants of the encoder frame sequencer.
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define SEQ_TALLY_W 8
`define SEQ_HALF_W 8
`define SEQ_BITPOS_W 4
`define SEQ_FIELD_W 4
`define SEQ_CRC_W 8
`define SEQ_CRC_POLY 8'h01
`define SEQ_CRC_INIT 8'h00
`define SEQ_FIELD_LAST_BIT 4'h9
`define SEQ_DATA_FIRST_BIT 4'h1
`define SEQ_DATA_LAST_BIT 4'h8
`define SEQ_ONE_HALF 8'h01
`define SEQ_ONE_TALLY 8'h01
`define SEQ_ONE_BIT 4'h1
`define SEQ_ONE_FIELD 4'h1
`endif

// >>> seq_pkg.sv
// Types shared by the frame sequencer modules.
package seq_pkg;
   // Declaration order gives idle=00, send=01, wait=10, collect=11.
   typedef enum logic [1:0] {
      idle_st,
      send_st,
      reply_wait_st,
      collect_st
   } frame_state_t;
endpackage

// >>> crc_link_if.sv
// Carrier between the frame sequencer and its reply check-value LFSR.
`include "seq_defs.svh"
interface crc_link_if;
   logic shift;
   logic bit_in;
   logic clear;
   logic [`SEQ_CRC_W-1:0] value;
   modport seq (output shift, output bit_in, output clear, input value);
   modport lfsr (input shift, input bit_in, input clear, output value);
endinterface

// >>> reply_crc_lfsr.sv
// LFSR that folds received reply data bits into the running check value.
`include "seq_defs.svh"
module reply_crc_lfsr
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   crc_link_if.lfsr link
);
   logic [`SEQ_CRC_W-1:0] crc_ff;
   logic feedback;

   assign feedback = crc_ff[`SEQ_CRC_W-1] ^ link.bit_in;
   assign link.value = crc_ff;

   always_ff @(posedge clk) begin
      if (rst || link.clear) begin
         crc_ff <= `SEQ_CRC_INIT;
      end else if (link.shift) begin
         crc_ff <= {crc_ff[`SEQ_CRC_W-2:0], 1'b0} ^
                   (feedback ? `SEQ_CRC_POLY : `SEQ_CRC_INIT);
      end
   end
endmodule

// >>> encoder_frame_sequencer.sv
// Frame sequencer for a half-duplex encoder link with reply clock alignment.
`include "seq_defs.svh"
// Operation
// - States idle=00, send=01, wait=10, collect=11; idle goes to send on event.
// - Send holds until the clock tally completes, then goes to reply wait.
// - Collect holds until the clock tally completes, then returns to idle.
// - Reply wait goes to collect on the event, ignoring tally completion.
// - Frame active output is the OR of both state bits.
// - Event is reply falling edge in reply wait, or launch rising edge.
// - Edge-timing counter reset instant sets the shift clock phase.
// - Half-period hit resets the edge-timing counter, setting phase width.
// - In reply wait or collect, any reply edge resets the counter.
// - Reply check value computed on the fly by an LFSR fed received data.
// - LFSR shifts only in collect on the eight data bits of a field.
// - LFSR never shifts during the final check field.
// - Line driver enable high throughout send, low once send completes.
// - Shift clock reaches the shifter only in send and collect.
// - Entering collect, match becomes current tally plus reply clock count.
// - Rising edge of the start input gives a one-clock launch pulse.
module encoder_frame_sequencer
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start_req,
   input wire logic sensor_reply_line,
   input wire logic [`SEQ_TALLY_W-1:0] send_clocks,
   input wire logic [`SEQ_TALLY_W-1:0] reply_clocks,
   input wire logic [`SEQ_FIELD_W-1:0] reply_fields,
   input wire logic [`SEQ_HALF_W-1:0] half_period,
   output logic [1:0] frame_state,
   output logic frame_active,
   output logic line_driver_enable,
   output logic serial_shift_clock,
   output logic [`SEQ_CRC_W-1:0] crc_value
);
   frame_state_t state_ff, nxt_state;
   logic reply_meta_ff, reply_sync_ff, reply_prev_ff, start_prev_ff;
   logic reply_fall, reply_any, launch_pulse, phase_advance_event;
   logic [`SEQ_HALF_W-1:0] edge_cnt_ff;
   logic half_period_hit, align_reset, gen_clk_ff, clk_enabled, rise_ev;
   logic nxt_gen_clk, nxt_clk_enabled;
   logic [`SEQ_TALLY_W-1:0] tally_ff, match_ff;
   logic clock_tally_done;
   logic [`SEQ_BITPOS_W-1:0] bit_pos_ff;
   logic [`SEQ_FIELD_W-1:0] field_ff;
   logic data_bit, check_field;
   logic driver_ff, shift_clk_ff;
   crc_link_if crc_link ();

   // The reply pin is asynchronous, so it passes two flops before use.
   always_ff @(posedge clk) begin
      if (rst) begin
         reply_meta_ff <= 1'b1;
         reply_sync_ff <= 1'b1;
         reply_prev_ff <= 1'b1;
      end else begin
         reply_meta_ff <= sensor_reply_line;
         reply_sync_ff <= reply_meta_ff;
         reply_prev_ff <= reply_sync_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         start_prev_ff <= 1'b0;
      end else begin
         start_prev_ff <= start_req;
      end
   end

   assign reply_fall = reply_prev_ff & ~reply_sync_ff;
   assign reply_any = reply_prev_ff ^ reply_sync_ff;
   assign launch_pulse = start_req & ~start_prev_ff;

   assign phase_advance_event =
      ((state_ff == reply_wait_st) & reply_fall) | launch_pulse;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         idle_st: begin
            if (phase_advance_event) begin
               nxt_state = send_st;
            end
         end
         send_st: begin
            if (clock_tally_done) begin
               nxt_state = reply_wait_st;
            end
         end
         reply_wait_st: begin
            if (phase_advance_event) begin
               nxt_state = collect_st;
            end
         end
         collect_st: begin
            if (clock_tally_done) begin
               nxt_state = idle_st;
            end
         end
         default: begin
            nxt_state = idle_st;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= idle_st;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign frame_state = state_ff;
   assign frame_active = frame_state[1] | frame_state[0];

   assign half_period_hit = edge_cnt_ff == (half_period - `SEQ_ONE_HALF);
   assign align_reset = reply_any &
      ((state_ff == reply_wait_st) | (state_ff == collect_st));

   always_ff @(posedge clk) begin
      if (rst || half_period_hit || align_reset) begin
         edge_cnt_ff <= '0;
      end else begin
         edge_cnt_ff <= edge_cnt_ff + `SEQ_ONE_HALF;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || align_reset) begin
         gen_clk_ff <= 1'b0;
      end else if (half_period_hit) begin
         gen_clk_ff <= ~gen_clk_ff;
      end
   end

   // clock passes in send and collect.
   assign clk_enabled = (state_ff == send_st) | (state_ff == collect_st);
   assign rise_ev = clk_enabled & half_period_hit & ~gen_clk_ff &
                    ~align_reset;

   // Gating on the next state and clock value keeps the registered output
   // from showing a stale high cycle after send or collect has ended.
   assign nxt_gen_clk = align_reset ? 1'b0 :
                        (half_period_hit ? ~gen_clk_ff : gen_clk_ff);
   assign nxt_clk_enabled = (nxt_state == send_st) |
                            (nxt_state == collect_st);

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_clk_ff <= 1'b0;
      end else begin
         shift_clk_ff <= nxt_gen_clk & nxt_clk_enabled;
      end
   end
   assign serial_shift_clock = shift_clk_ff;

   // The tally counts generated shift-clock rises in send and collect.
   always_ff @(posedge clk) begin
      if (rst || launch_pulse) begin
         tally_ff <= '0;
      end else if (rise_ev) begin
         tally_ff <= tally_ff + `SEQ_ONE_TALLY;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         match_ff <= '0;
      end else if (launch_pulse && state_ff == idle_st) begin
         match_ff <= send_clocks;
      end else if (state_ff == reply_wait_st && phase_advance_event) begin
         match_ff <= tally_ff + reply_clocks;
      end
   end
   assign clock_tally_done = tally_ff == match_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         driver_ff <= 1'b0;
      end else begin
         driver_ff <= nxt_state == send_st;
      end
   end
   assign line_driver_enable = driver_ff;

   // Bit position and field index within the reply, advanced per rise.
   always_ff @(posedge clk) begin
      if (rst || state_ff != collect_st) begin
         bit_pos_ff <= '0;
         field_ff <= '0;
      end else if (rise_ev) begin
         if (bit_pos_ff == `SEQ_FIELD_LAST_BIT) begin
            bit_pos_ff <= '0;
            field_ff <= field_ff + `SEQ_ONE_FIELD;
         end else begin
            bit_pos_ff <= bit_pos_ff + `SEQ_ONE_BIT;
         end
      end
   end

   assign data_bit = (bit_pos_ff >= `SEQ_DATA_FIRST_BIT) &&
                     (bit_pos_ff <= `SEQ_DATA_LAST_BIT);
   assign check_field = field_ff == (reply_fields - `SEQ_ONE_FIELD);

   assign crc_link.shift = rise_ev & (state_ff == collect_st) &
                           data_bit & ~check_field;
   assign crc_link.bit_in = reply_sync_ff;
   // A new frame starts from a clean seed so stale replies never mix in.
   assign crc_link.clear = launch_pulse;
   assign crc_value = crc_link.value;

   reply_crc_lfsr u_crc (
      .clk(clk),
      .rst(rst),
      .link(crc_link.lfsr)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_IDLE_LAUNCH: assert property (
      state_ff == idle_st && phase_advance_event |=> state_ff == send_st)
      else $error("Idle did not move to send on the event.");
   AST_SEND_DONE: assert property (
      state_ff == send_st && clock_tally_done |=> state_ff == reply_wait_st)
      else $error("Send did not end on tally completion.");
   AST_COLLECT_DONE: assert property (
      state_ff == collect_st && clock_tally_done |=> state_ff == idle_st)
      else $error("Collect did not return to idle.");
   AST_WAIT_HOLD: assert property (
      state_ff == reply_wait_st && !phase_advance_event
      |=> state_ff == reply_wait_st)
      else $error("Reply wait left without an event.");
   AST_ACTIVE_RISE: assert property (
      $rose(frame_active) |-> $past(launch_pulse))
      else $error("Frame became active without a launch.");
   AST_REPLY_START: assert property (
      state_ff == reply_wait_st && reply_fall |=> state_ff == collect_st)
      else $error("Reply falling edge did not start collection.");
   AST_HALF_RESET: assert property (
      half_period_hit |=> edge_cnt_ff == '0)
      else $error("Edge counter not reset at half period.");
   AST_ALIGN: assert property (
      align_reset |=> edge_cnt_ff == '0 && !gen_clk_ff)
      else $error("Reply edge did not realign the clock.");
   AST_SHIFT_COLLECT: assert property (
      crc_link.shift |-> state_ff == collect_st && data_bit)
      else $error("LFSR shifted outside a data bit.");
   AST_NO_CHECK: assert property (
      check_field && state_ff == collect_st |-> !crc_link.shift)
      else $error("Check field reached the LFSR.");
   AST_DRIVER: assert property (
      line_driver_enable == (state_ff == send_st))
      else $error("Driver enable does not follow send.");
   AST_GATE: assert property (
      state_ff != send_st && state_ff != collect_st |-> !serial_shift_clock)
      else $error("Shift clock leaked outside send and collect.");
   AST_MATCH: assert property (
      state_ff == collect_st && $past(state_ff) == reply_wait_st
      |-> match_ff == $past(tally_ff) + $past(reply_clocks))
      else $error("Match not extended on collect entry.");
   AST_LAUNCH_ONE: assert property (
      launch_pulse |=> !launch_pulse)
      else $error("Launch pulse longer than one clock.");

   COV_FRAME: cover property (
      state_ff == collect_st ##1 state_ff == idle_st);
   COV_ALIGN: cover property (state_ff == collect_st && align_reset);
   COV_SHIFT: cover property (crc_link.shift);
endmodule

// >>> encoder_model.sv
// Behavioural encoder that answers each request with a framed reply.
module encoder_model #(
   parameter logic [23:0] REPLY = 24'h00_0000
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_driver_enable,
   input wire logic [7:0] half_period,
   input wire logic [31:0] delay,
   output logic reply_line
);
   timeunit 1ns;
   timeprecision 1ns;
   int f;
   int b;
   // The pair is biased high, so an idle line reads as a one.
   initial reply_line = 1'b1;
   // reply only after the master releases the line
   always @(negedge line_driver_enable) begin
      if (!rst) begin
         // The delay stands in for cable and encoder turnaround time.
         repeat (delay) @(posedge clk);
         for (f = 0; f < 3; f++) begin
            for (b = 0; b < 10; b++) begin
               #1;
               reply_line = (b == 9) || (b != 0 && REPLY[f*8+b-1]);
               repeat (2 * half_period) @(posedge clk);
            end
         end
      end
   end
endmodule

// >>> encoder_frame_sequencer_tb.sv
// Self-checking bench for the encoder frame sequencer.
module encoder_frame_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import seq_pkg::*;
   localparam logic [23:0] REPLY = 24'hc3_3ca5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start_req = 1'b0;
   logic reply_line;
   logic [7:0] send_clocks = 8'h0a;
   logic [7:0] reply_clocks = 8'h1e;
   logic [3:0] reply_fields = 4'h3;
   logic [7:0] half_period = 8'h02;
   logic [1:0] frame_state;
   logic frame_active;
   logic line_driver_enable;
   logic serial_shift_clock;
   logic [7:0] crc_value;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int delay = 5;
   int n;
   logic seen_clk;
   initial forever #50 clk = ~clk;
   encoder_frame_sequencer dut_u (.clk(clk), .rst(rst),
      .start_req(start_req), .sensor_reply_line(reply_line),
      .send_clocks(send_clocks), .reply_clocks(reply_clocks),
      .reply_fields(reply_fields), .half_period(half_period),
      .frame_state(frame_state), .frame_active(frame_active),
      .line_driver_enable(line_driver_enable),
      .serial_shift_clock(serial_shift_clock), .crc_value(crc_value));
   encoder_model #(.REPLY(REPLY)) model_u (.clk(clk), .rst(rst),
      .line_driver_enable(line_driver_enable), .half_period(half_period),
      .delay(delay), .reply_line(reply_line));
   task automatic print_verdict;
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Inputs change and outputs are read one nanosecond after the edge.
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input logic [1:0] s, input int lim);
      n = 0;
      seen_clk = 1'b0;
      while (frame_state !== s && n < lim) begin
         if (serial_shift_clock === 1'b1) begin
            seen_clk = 1'b1;
         end
         step(1);
         n++;
      end
   endtask
   // Only the first two fields count; the third is the check field.
   function automatic logic [7:0] crc_of(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 16; i++) begin
         c = {c[6:0], c[7] ^ d[i]};
      end
      return c;
   endfunction
   task automatic t_reset;
      chk_val({6'h00, frame_state}, 8'h00);
      chk_flag(line_driver_enable, 1'b0);
      chk_flag(serial_shift_clock, 1'b0);
      chk_val(crc_value, 8'h00);
   endtask
   task automatic t_frame(input logic [7:0] h, input int dly);
      int hp;
      logic ok;
      hp = 2 * h;
      half_period = h;
      delay = dly;
      start_req = 1'b1;
      step(1);
      chk_val({6'h00, frame_state}, 8'h01);
      chk_flag(frame_active, 1'b1);
      chk_flag(line_driver_enable, 1'b1);
      wait_st(2'h2, 1000);
      chk_flag(seen_clk, 1'b1);
      ok = n >= (send_clocks - 1) * hp && n <= send_clocks * hp + 2;
      chk_flag(ok, 1'b1);
      chk_flag(line_driver_enable, 1'b0);
      chk_flag(serial_shift_clock, 1'b0);
      step(3);
      chk_flag(serial_shift_clock, 1'b0);
      chk_flag(frame_active, 1'b1);
      wait_st(2'h3, dly + 40);
      chk_flag(seen_clk, 1'b0);
      chk_flag(n >= dly - 1 && n <= dly + 3, 1'b1);
      wait_st(2'h0, reply_clocks * hp + 60);
      chk_flag(seen_clk, 1'b1);
      ok = n >= (reply_clocks - 1) * hp && n <= reply_clocks * hp + hp + 8;
      chk_flag(ok, 1'b1);
      chk_flag(serial_shift_clock, 1'b0);
      chk_flag(frame_active, 1'b0);
      chk_val(crc_value, crc_of(REPLY));
      // Start held high must not relaunch; only its rising edge counts.
      step(5);
      chk_val({6'h00, frame_state}, 8'h00);
      chk_flag(serial_shift_clock, 1'b0);
      start_req = 1'b0;
      step(2);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_frame(8'h02, 5);
      t_frame(8'h03, 17);
      print_verdict();
   end
endmodule
